// ==== include/fzmgr_regs.vh ====
// Constants for the freeze-mode entry manager: register map, fields, resets, timing.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef FZMGR_REGS_VH
`define FZMGR_REGS_VH

// Register byte offsets (APB, one 32-bit word each)
`define FZ_CTRL_OFS      12'h000
`define FZ_STATUS_OFS    12'h004

// Control register fields
`define FZ_CTRL_HK_EN    0
`define FZ_CTRL_TYPE2    1
`define FZ_CTRL_POL_HIGH 2
`define FZ_CTRL_RESET    3'h5

// Status register fields
`define FZ_ST_STATE_LSB  0
`define FZ_ST_STATE_MSB  2
`define FZ_ST_PIN        4
`define FZ_ST_PREP       5
`define FZ_ST_RUN        6
`define FZ_ST_LPCTL      7
`define FZ_ST_MODE       8

// Timing
`define FZ_CLK_NS        100
`define FZ_GLITCH_NS     1000
`define FZ_GLITCH_CYC    ((`FZ_GLITCH_NS + `FZ_CLK_NS - 1) / `FZ_CLK_NS)
`define FZ_SETTLE_CYC    4'h4
`define FZ_WAKE_CYC      4'h2

`endif

// ==== logic/fzmgr_clk_gate.v ====
// Glitch-free gate for one clock.
// Assumes run_req comes from another domain; the output is held low while stopped.
`timescale 1ns/100ps
`default_nettype none

module fzmgr_clk_gate (
	// Clock in and reset
	input  wire clk_in,
	input  wire sys_rst,
	// Control
	input  wire run_req,
	// Gated clock
	output wire clk_out
);

	reg sync1_reg;
	reg sync2_reg;
	reg en_low_reg;

	always @(posedge clk_in or posedge sys_rst) begin
		if (sys_rst) begin
			sync1_reg <= 1'b1;
			sync2_reg <= 1'b1;
		end else begin
			sync1_reg <= run_req;
			sync2_reg <= sync1_reg;
		end
	end

	// Enable only changes while the clock is low, so no partial pulse
	always @(negedge clk_in or posedge sys_rst) begin
		if (sys_rst)
			en_low_reg <= 1'b1;
		else
			en_low_reg <= sync2_reg;
	end

	assign clk_out = clk_in & en_low_reg;

endmodule // fzmgr_clk_gate
`default_nettype wire

// ==== logic/fzmgr_pin_filter.v ====
// Freeze pin synchroniser and persistence filter.
// Assumes the pin is asynchronous and active low; output is active-high, filtered.
`timescale 1ns/100ps
`default_nettype none
`include "fzmgr_regs.vh"

module fzmgr_pin_filter #(
	parameter integer GLITCH_CYC = `FZ_GLITCH_CYC
) (
	// Clock and reset
	input  wire clk,
	input  wire sys_rst,
	// Pin and result
	input  wire freeze_pin_n,
	output reg  pin_asserted_reg
);

	// Counter is eight bits, so a window above 256 cycles is not supported
	localparam [31:0] GLITCH_W = GLITCH_CYC;

	reg       sync1_reg;
	reg       sync2_reg;
	reg [7:0] stable_reg;

	// First stage feeds only the second stage
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sync1_reg <= 1'b1;
			sync2_reg <= 1'b1;
		end else begin
			sync1_reg <= freeze_pin_n;
			sync2_reg <= sync1_reg;
		end
	end

	// Level must hold GLITCH_CYC cycles before it is believed
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			stable_reg       <= 8'h00;
			pin_asserted_reg <= 1'b0;
		end else if ((~sync2_reg) == pin_asserted_reg) begin
			stable_reg <= 8'h00;
		end else if (stable_reg == GLITCH_W[7:0] - 8'h01) begin
			stable_reg       <= 8'h00;
			pin_asserted_reg <= ~sync2_reg;
		end else begin
			stable_reg <= stable_reg + 8'h01;
		end
	end

endmodule // fzmgr_pin_filter
`default_nettype wire

// ==== logic/fzmgr_top.v ====
// Freeze-mode entry manager: APB registers, sequencer, clock filters.
// Assumes clk is free running at 10 MHz and aux clocks are free running too.
//
// Notes on behaviour
// - Freeze pin low means asserted, high means deasserted.
// - Freeze pin must be persistent before entry; short glitches are ignored.
// - Persistent freeze request raises prep request to user logic.
// - Gated clocks stop only after prep done is seen.
// - After clocks stop, low-power entry control is asserted.
// - Pin deassertion wakes the sequencer; bad states recover to idle.
// - Wake deasserts low-power control first, then releases gated clocks.
// - Type one: freeze mode follows the pin only.
// - Type two: freeze mode needs pin and low-power entry control.
// - One main filter plus zero to sixteen auxiliary filters.
// - Sequencer runs on primary clock; gated copy is output.
// - Housekeeping disabled loops prep request back to prep done.
// - Freeze-entering output with selectable polarity marks freeze entry.
`timescale 1ns/100ps
`default_nettype none
`include "fzmgr_regs.vh"

module fzmgr_top #(
	parameter integer EXTRA_CLOCK_COUNT = 16,
	parameter integer GLITCH_CYC        = `FZ_GLITCH_CYC
) (
	// Clock and reset
	input  wire        clk,
	input  wire        sys_rst,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// Freeze pin
	input  wire        freeze_pin_n,
	// Housekeeping handshake
	output reg         prep_req,
	input  wire        prep_done,
	// Low-power macro control and freeze indications
	output reg         lowpower_entry_ctl,
	output reg         freeze_mode,
	output reg         freeze_entering,
	// Clocks
	output wire        clk_gated,
	input  wire [15:0] aux_clk_in,
	output wire [15:0] aux_clk_out
);

	////////////////////////////////////////////////////////////////////
	// States

	localparam [2:0] ST_IDLE    = 3'h0;
	localparam [2:0] ST_PREP    = 3'h1;
	localparam [2:0] ST_STOP    = 3'h2;
	localparam [2:0] ST_FREEZE  = 3'h3;
	localparam [2:0] ST_WAKE    = 3'h4;
	localparam [2:0] ST_RELEASE = 3'h5;

	reg  [2:0] ctrl_reg;
	reg  [2:0] state_reg;
	reg  [2:0] state_next;
	reg  [3:0] cnt_reg;
	reg  [3:0] cnt_next;
	reg        run_reg;
	reg        run_next;
	reg        prep_next;
	reg        lpctl_next;
	wire       pin_ok;
	wire       done_eff;
	wire       hk_en;
	wire       type2;
	wire       pol_high;

	assign hk_en    = ctrl_reg[`FZ_CTRL_HK_EN];
	assign type2    = ctrl_reg[`FZ_CTRL_TYPE2];
	assign pol_high = ctrl_reg[`FZ_CTRL_POL_HIGH];

	function is_ofs;
		input [11:0] addr;
		input [11:0] ofs;
		begin
			is_ofs = (addr == ofs);
		end
	endfunction

	function [3:0] tick_down;
		input [3:0] cnt;
		begin
			tick_down = cnt - 4'h1;
		end
	endfunction

	function is_entry_state;
		input [2:0] st;
		begin
			is_entry_state = (st == ST_STOP) | (st == ST_FREEZE);
		end
	endfunction

	////////////////////////////////////////////////////////////////////
	// Pin filter

	fzmgr_pin_filter #(
		.GLITCH_CYC (GLITCH_CYC)
	) u_pin (
		.clk              (clk),
		.sys_rst          (sys_rst),
		.freeze_pin_n     (freeze_pin_n),
		.pin_asserted_reg (pin_ok)
	);

	// Bypass keeps the sequence intact without user involvement
	assign done_eff = hk_en ? prep_done : prep_req;

	////////////////////////////////////////////////////////////////////
	// APB slave: one wait state, pready from a flop

	wire apb_access;
	wire apb_done;
	wire addr_ok;

	assign apb_access = psel & penable;
	assign apb_done   = apb_access & pready;
	assign addr_ok    = is_ofs(paddr, `FZ_CTRL_OFS) | is_ofs(paddr, `FZ_STATUS_OFS);

	// Read words placed by the field positions of the constants header
	reg [31:0] ctrl_word;
	reg [31:0] status_word;

	always @* begin
		ctrl_word                                      = 32'h0000_0000;
		ctrl_word[`FZ_CTRL_HK_EN]                      = hk_en;
		ctrl_word[`FZ_CTRL_TYPE2]                      = type2;
		ctrl_word[`FZ_CTRL_POL_HIGH]                   = pol_high;
		status_word                                    = 32'h0000_0000;
		status_word[`FZ_ST_STATE_MSB:`FZ_ST_STATE_LSB] = state_reg;
		status_word[`FZ_ST_PIN]                        = pin_ok;
		status_word[`FZ_ST_PREP]                       = prep_req;
		status_word[`FZ_ST_RUN]                        = run_reg;
		status_word[`FZ_ST_LPCTL]                      = lowpower_entry_ctl;
		status_word[`FZ_ST_MODE]                       = freeze_mode;
	end

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (apb_access & ~pready) begin
			pready  <= 1'b1;
			pslverr <= ~addr_ok;
			if (~pwrite & is_ofs(paddr, `FZ_CTRL_OFS))
				prdata <= ctrl_word;
			else if (~pwrite & is_ofs(paddr, `FZ_STATUS_OFS))
				prdata <= status_word;
			else
				prdata <= 32'h0000_0000;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
	end

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			ctrl_reg <= `FZ_CTRL_RESET;
		else if (apb_done & pwrite & is_ofs(paddr, `FZ_CTRL_OFS))
			ctrl_reg <= pwdata[2:0];
	end

	////////////////////////////////////////////////////////////////////
	// Sequencer

	always @* begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		run_next   = run_reg;
		prep_next  = prep_req;
		lpctl_next = lowpower_entry_ctl;
		case (state_reg)
		ST_IDLE: begin
			run_next   = 1'b1;
			lpctl_next = 1'b0;
			if (pin_ok) begin
				state_next = ST_PREP;
				prep_next  = 1'b1;
			end
		end
		ST_PREP: begin
			if (~pin_ok) begin
				// Request withdrawn before housekeeping ended
				state_next = ST_IDLE;
				prep_next  = 1'b0;
			end else if (done_eff) begin
				state_next = ST_STOP;
				prep_next  = 1'b0;
				run_next   = 1'b0;
				cnt_next   = `FZ_SETTLE_CYC;
			end
		end
		ST_STOP: begin
			// Wait until every gate has seen the stop
			if (~pin_ok) begin
				state_next = ST_WAKE;
				cnt_next   = `FZ_WAKE_CYC;
			end else if (cnt_reg == 4'h0) begin
				state_next = ST_FREEZE;
				lpctl_next = 1'b1;
			end else begin
				cnt_next = tick_down(cnt_reg);
			end
		end
		ST_FREEZE: begin
			if (~pin_ok) begin
				state_next = ST_WAKE;
				lpctl_next = 1'b0;
				cnt_next   = `FZ_WAKE_CYC;
			end
		end
		ST_WAKE: begin
			lpctl_next = 1'b0;
			if (cnt_reg == 4'h0) begin
				state_next = ST_RELEASE;
				run_next   = 1'b1;
				cnt_next   = `FZ_SETTLE_CYC;
			end else begin
				cnt_next = tick_down(cnt_reg);
			end
		end
		ST_RELEASE: begin
			// Let gates restart before a new entry can begin
			if (cnt_reg == 4'h0)
				state_next = ST_IDLE;
			else
				cnt_next = tick_down(cnt_reg);
		end
		default: begin
			state_next = ST_IDLE;
			run_next   = 1'b1;
			prep_next  = 1'b0;
			lpctl_next = 1'b0;
			cnt_next   = 4'h0;
		end
		endcase
	end

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg          <= ST_IDLE;
			cnt_reg            <= 4'h0;
			run_reg            <= 1'b1;
			prep_req           <= 1'b0;
			lowpower_entry_ctl <= 1'b0;
			freeze_mode        <= 1'b0;
			freeze_entering    <= 1'b0;
		end else begin
			state_reg          <= state_next;
			cnt_reg            <= cnt_next;
			run_reg            <= run_next;
			prep_req           <= prep_next;
			lowpower_entry_ctl <= lpctl_next;
			if (type2)
				freeze_mode <= pin_ok & lpctl_next;
			else
				freeze_mode <= pin_ok;
			freeze_entering <= is_entry_state(state_next) ^ ~pol_high;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Clock filters

	fzmgr_clk_gate u_main_gate (
		.clk_in  (clk),
		.sys_rst (sys_rst),
		.run_req (run_reg),
		.clk_out (clk_gated)
	);

	genvar g;
	generate
		for (g = 0; g < 16; g = g + 1) begin : g_aux
			if (g < EXTRA_CLOCK_COUNT) begin : g_on
				fzmgr_clk_gate u_gate (
					.clk_in  (aux_clk_in[g]),
					.sys_rst (sys_rst),
					.run_req (run_reg),
					.clk_out (aux_clk_out[g])
				);
			end else begin : g_off
				assign aux_clk_out[g] = 1'b0;
			end
		end
	endgenerate

endmodule // fzmgr_top
`default_nettype wire

// ==== tb/fzmgr_assertions.sv ====
// Checker for the freeze-mode entry manager, seeing top ports only.
// Assumes a bind to fzmgr_top run with a small glitch filter.
`timescale 1ns/100ps
`default_nettype none
module fzmgr_checker (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Watched ports
	input wire logic freeze_pin_n,
	input wire logic prep_req,
	input wire logic prep_done,
	input wire logic lowpower_entry_ctl,
	input wire logic freeze_mode
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Eight samples cover sync plus filter with margin
	sequence s_pin_high; freeze_pin_n [*8]; endsequence
	sequence s_handoff; prep_req && prep_done; endsequence
	prep_rise_a: assert property ($rose(prep_req) |-> $past(!freeze_pin_n, 2))
		else $error("prep request without held pin");
	handoff_ack_a: assert property (s_handoff |=> !prep_req)
		else $error("prep request kept after done");
	lp_after_stop_a: assert property ($rose(lowpower_entry_ctl) |-> $past(!prep_req, 4))
		else $error("control raised too soon");
	lp_no_prep_a: assert property (lowpower_entry_ctl |-> !prep_req)
		else $error("control high during prep");
	mode_rise_a: assert property ($rose(freeze_mode) |-> $past(!freeze_pin_n, 2))
		else $error("freeze mode without pin");
	wake_lp_a: assert property (s_pin_high |-> !lowpower_entry_ctl)
		else $error("control kept after wake");
	wake_prep_a: assert property (s_pin_high |-> !prep_req)
		else $error("prep request without pin");
	reset_idle_a: assert property (disable iff (1'b0) sys_rst |=>
		!prep_req && !lowpower_entry_ctl && !freeze_mode) else $error("not idle in reset");
endmodule // fzmgr_checker
bind fzmgr_top fzmgr_checker chk_u (.clk(clk), .sys_rst(sys_rst),
	.freeze_pin_n(freeze_pin_n), .prep_req(prep_req), .prep_done(prep_done),
	.lowpower_entry_ctl(lowpower_entry_ctl), .freeze_mode(freeze_mode));
`default_nettype wire

// ==== tb/fzmgr_user_model.sv ====
// User-side model: answers housekeeping, counts gated clock edges.
// Assumes prep_req is a level; lat of 15 is slower than any bypass.
`timescale 1ns/100ps
`default_nettype none
module fzmgr_user_model (
	// Clocks and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        clk_gated,
	// Handshake
	input  wire logic        prep_req,
	input  wire logic [3:0]  lat,
	output var  logic        prep_done,
	output var  logic [15:0] edges
);
	logic [3:0] cnt;
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst || !prep_req) begin
			cnt <= 4'h0;
			prep_done <= 1'b0;
		end else if (cnt == lat) prep_done <= 1'b1;
		else cnt <= cnt + 4'h1;
	end
	// Stands in for a state-keeping user domain
	always @(posedge clk_gated or posedge sys_rst) begin
		if (sys_rst) edges <= 16'h0000;
		else edges <= edges + 16'h0001;
	end
endmodule // fzmgr_user_model
`default_nettype wire

// ==== tb/tb.sv ====
// Testbench for the freeze-mode entry manager.
// Assumes the bound checker and the user model beside the design.
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic        clk = 0, aux = 0, sys_rst = 0, psel = 0, penable = 0, pwrite = 0, pin = 1;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd, d;
	logic        pready, pslverr, prep_req, prep_done, lp, fm, fe, cg, er;
	logic [15:0] ao, ao3, edges, ed0;
	logic [3:0]  lat = 0;
	int          n_fail = 0, total_checks = 0, i, v;
	always #50 clk = ~clk;
	always #37 aux = ~aux;
	fzmgr_top #(.EXTRA_CLOCK_COUNT(16), .GLITCH_CYC(2)) dut_u (.clk(clk), .sys_rst(sys_rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .freeze_pin_n(pin),
		.prep_req(prep_req), .prep_done(prep_done), .lowpower_entry_ctl(lp),
		.freeze_mode(fm), .freeze_entering(fe), .clk_gated(cg),
		.aux_clk_in({16{aux}}), .aux_clk_out(ao));
	fzmgr_user_model usr_u (.clk(clk), .sys_rst(sys_rst), .clk_gated(cg),
		.prep_req(prep_req), .lat(lat), .prep_done(prep_done), .edges(edges));
	// Narrow build: three aux filters, the rest tied low
	fzmgr_top #(.EXTRA_CLOCK_COUNT(3), .GLITCH_CYC(2)) dut3_u (.clk(clk), .sys_rst(sys_rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(), .pready(), .pslverr(), .freeze_pin_n(pin), .prep_req(),
		.prep_done(prep_done), .lowpower_entry_ctl(), .freeze_mode(), .freeze_entering(),
		.clk_gated(), .aux_clk_in({16{aux}}), .aux_clk_out(ao3));
	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", nm, exp, got);
			n_fail++;
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	function automatic logic [31:0] ctl_exp(input logic [31:0] wd);
		return wd & 32'h0000_0007;
	endfunction
	////////////////////////////////////////////////////////////////
	initial begin
		#1_000_000;
		n_fail++;
		end_sim();
	end
	initial begin
		sys_rst <= 1;
		v = $urandom(32'ha6e9_7072);
		repeat (20) @(posedge clk);
		sys_rst <= 0;
		apb(0, 12'h000, 0);
		chk("ctrl reset", 32'h0000_0005, rd);
		apb(0, 12'h004, 0);
		chk("status reset", 32'h0000_0040, rd);
		apb(0, 12'h008, 0);
		chk("unmapped error", 1, er);
		@(posedge clk) pin <= 0;
		@(posedge clk) pin <= 1;
		repeat (20) @(posedge clk) chk("glitch prep", 0, prep_req);
		$display("test reset and glitch done");
		for (v = 0; v < 8; v++) begin
			d = ($urandom << 3) | v;
			apb(1, 12'h000, d);
			apb(0, 12'h000, 0);
			chk("ctrl rw", ctl_exp(d), rd);
			lat <= v[0] ? 4'($urandom % 8) : 4'hf;
			@(posedge clk) pin <= 0;
			for (i = 0; i < 40 && prep_req !== 1'b1; i++) @(posedge clk);
			chk("prep rise", 1, prep_req);
			@(posedge clk);
			chk("mode by type", !v[1], fm);
			for (i = 0; i < 40 && lp !== 1'b1; i++) @(posedge clk);
			chk("bypass time", 1, v[0] || i < 12);
			chk("control on", 1, lp);
			chk("entering", v[2], fe);
			chk("mode in freeze", 1, fm);
			ed0 = edges;
			repeat (5) @(posedge clk);
			chk("clock stopped", ed0, edges);
			chk("gated low", 0, {cg, ao});
			chk("narrow gates low", 0, ao3);
			@(posedge clk) pin <= 1;
			for (i = 0; i < 40 && lp !== 1'b0; i++) @(posedge clk);
			chk("control off", 0, lp);
			chk("held at wake", ed0, edges);
			repeat (12) @(posedge clk);
			chk("clock back", 1, edges != ed0);
			chk("unused aux low", 0, ao3[15:3]);
			chk("entering off", !v[2], fe);
			apb(0, 12'h004, 0);
			chk("idle again", 0, rd[2:0]);
		end
		$display("test modes done");
		apb(1, 12'h000, 32'h0000_0005);
		lat <= 4'hf;
		@(posedge clk) pin <= 0;
		for (i = 0; i < 40 && prep_req !== 1'b1; i++) @(posedge clk);
		@(posedge clk) pin <= 1;
		repeat (12) @(posedge clk);
		chk("abort prep", 0, prep_req);
		chk("abort control", 0, lp);
		apb(0, 12'h004, 0);
		chk("abort idle", 0, rd[2:0]);
		$display("test abort done");
		apb(1, 12'h000, 32'h0000_0006);
		@(posedge clk) pin <= 0;
		for (i = 0; i < 40 && lp !== 1'b1; i++) @(posedge clk);
		chk("freeze before reset", 1, lp);
		sys_rst <= 1;
		pin <= 1;
		repeat (2) @(posedge clk);
		chk("reset control", 0, lp);
		chk("reset mode", 0, fm);
		chk("reset entering", 0, fe);
		ed0 = edges;
		repeat (18) @(posedge clk);
		sys_rst <= 0;
		repeat (4) @(posedge clk);
		chk("reset clock runs", 1, edges != ed0);
		apb(0, 12'h000, 0);
		chk("ctrl after reset", 32'h0000_0005, rd);
		apb(0, 12'h004, 0);
		chk("status after reset", 32'h0000_0040, rd);
		$display("test mid reset done");
		end_sim();
	end
endmodule // tb
`default_nettype wire
